// ==== inc/lpm_pkg.sv ====
`default_nettype none
package lpm_pkg;
   // Widths of measurements, settings and the register bus
   localparam int MEAS_W = 16;
   localparam int DLY_W  = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_OC_LIM  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_OC_DLY  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_OP_LIM  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_OP_DLY  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_UV_LIM  = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_UV_DLY  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_UV_WARM = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_STAT    = 8'h24;

   // Control register bit positions
   localparam int CTRL_OC_EN   = 0;
   localparam int CTRL_OP_EN   = 1;
   localparam int CTRL_UV_EN   = 2;
   localparam int CTRL_BEEP_EN = 3;
   localparam int CTRL_W       = 4;

   // Command register bit positions (write one to act)
   localparam int CMD_CLEAR = 0;
   localparam int CMD_ON    = 1;
   localparam int CMD_OFF   = 2;

   // Status register bit positions
   localparam int STAT_PROT      = 0;
   localparam int STAT_ON        = 1;
   localparam int STAT_WARM_DONE = 2;
   localparam int STAT_CAUSE_LSB = 4;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h8;
   localparam logic [MEAS_W-1:0] HI_LIM_RST = 16'hFFFF;
   localparam logic [MEAS_W-1:0] UV_LIM_RST = 16'h0000;
   localparam logic [DLY_W-1:0]  DLY_RST    = 16'h0000;

   // Timing: delays and warm-up count in ticks of TICK_US
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_US       = 1;
   localparam int TICK_CYC      = TICK_US * 1000 / CLK_PERIOD_NS;
   localparam int BEEP_MS       = 100;
   localparam int BEEP_CYC      = BEEP_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_ON   = 2'b01,
      ST_PROT = 2'b10
   } lpm_state_type;

   typedef enum logic [1:0] {
      CAUSE_NONE = 2'b00,
      CAUSE_OC   = 2'b01,
      CAUSE_OP   = 2'b10,
      CAUSE_UV   = 2'b11
   } lpm_cause_type;

   typedef struct packed {
      logic [MEAS_W-1:0] volt;
      logic [MEAS_W-1:0] curr;
      logic [MEAS_W-1:0] pow;
   } lpm_meas_type;

   typedef struct packed {
      logic esc;
      logic enter;
      logic input_key;
   } lpm_keys_type;

   typedef struct packed {
      logic              active;
      logic [MEAS_W-1:0] line1_volt;
      logic [MEAS_W-1:0] line1_curr;
      lpm_cause_type     line2_cause;
   } lpm_disp_type;
endpackage
`default_nettype wire

// ==== rtl/lpm_trip_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpm_trip_timer #(
   parameter int DLY_W = 16
) (
   input  wire logic             core_clk_in,
   input  wire logic             rstn_in,
   input  wire logic             enable_in,
   input  wire logic             violate_in,
   input  wire logic             tick_in,
   input  wire logic [DLY_W-1:0] delay_in,
   output logic                  trip_out
);
   import lpm_pkg::*;

   typedef struct packed {
      logic [DLY_W-1:0] cnt;
      logic             arm;
      logic             trip;
   } lpm_tmr_state_type;

   lpm_tmr_state_type tmr_reg;
   lpm_tmr_state_type tmr_next;

   // Count violation ticks; trip only once the full delay has passed
   always_comb begin
      tmr_next = tmr_reg;
      if (!(enable_in && violate_in)) begin
         tmr_next = '0;
      end else if (tmr_reg.arm && tmr_reg.cnt >= delay_in) begin
         tmr_next.trip = 1'b1;
      end else if (tick_in) begin
         // The first tick after onset is partial, so it only arms the count
         tmr_next.arm = 1'b1;
         if (tmr_reg.arm) begin
            tmr_next.cnt = tmr_reg.cnt + 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tmr_reg <= '0;
      end else begin
         tmr_reg <= tmr_next;
      end
   end

   assign trip_out = tmr_reg.trip;
endmodule
`default_nettype wire

// ==== rtl/lpm_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpm_monitor #(
   parameter int BEEP_CYCLES = lpm_pkg::BEEP_CYC
) (
   input  wire logic                        core_clk_in,
   input  wire logic                        rstn_in,
   input  wire logic [lpm_pkg::ADDR_W-1:0]  addr_in,
   input  wire logic [lpm_pkg::DATA_W-1:0]  wdata_in,
   input  wire logic                        wr_in,
   input  wire logic                        rd_in,
   output logic      [lpm_pkg::DATA_W-1:0]  rdata_out,
   input  wire lpm_pkg::lpm_meas_type       meas_in,
   input  wire lpm_pkg::lpm_keys_type       keys_in,
   input  wire logic                        rear_clear_in,
   output logic                             load_on_out,
   output logic                             prot_led_out,
   output logic                             off_led_out,
   output logic                             buzzer_out,
   output lpm_pkg::lpm_disp_type            front_display_out
);
   import lpm_pkg::*;

   localparam int TICK_W = $clog2(TICK_CYC + 1);
   localparam int BEEP_W = $clog2(BEEP_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
   localparam logic [BEEP_W-1:0] BEEP_LOAD = BEEP_W'(BEEP_CYCLES);

   typedef struct packed {
      lpm_state_type     st;
      logic [CTRL_W-1:0] ctrl;
      logic [MEAS_W-1:0] oc_lim;
      logic [MEAS_W-1:0] op_lim;
      logic [MEAS_W-1:0] uv_lim;
      logic [DLY_W-1:0]  oc_dly;
      logic [DLY_W-1:0]  op_dly;
      logic [DLY_W-1:0]  uv_dly;
      logic [DLY_W-1:0]  uv_warm;
      logic [DLY_W-1:0]  warm_cnt;
      logic              warm_done;
      logic              warm_arm;
      logic [TICK_W-1:0] tick_cnt;
      logic              tick;
      logic [2:0]        cause;
      logic [BEEP_W-1:0] beep_cnt;
      logic              buzz;
      logic              rear_prev;
      logic              load_on;
      logic              prot_led;
      logic              off_led;
      logic [DATA_W-1:0] rdata;
      lpm_disp_type      disp;
   } lpm_mon_state_type;

   lpm_mon_state_type mon_reg;
   lpm_mon_state_type mon_next;
   logic [2:0]        trips;
   logic [2:0]        viol;
   logic [2:0]        chk_en;

   // Limit comparisons against the live meter values
   // current above limit
   assign viol[0] = meas_in.curr > mon_reg.oc_lim;
   assign viol[1] = meas_in.pow > mon_reg.op_lim;
   assign viol[2] = meas_in.volt < mon_reg.uv_lim;

   // Checks only run while the input conducts; a check that is off restarts its counter
   // overcurrent enable
   assign chk_en[0] = mon_reg.ctrl[CTRL_OC_EN] && (mon_reg.st == ST_ON);
   assign chk_en[1] = mon_reg.ctrl[CTRL_OP_EN] && (mon_reg.st == ST_ON);
   assign chk_en[2] = mon_reg.ctrl[CTRL_UV_EN] && (mon_reg.st == ST_ON) && mon_reg.warm_done;

   // One delay timer per check
   lpm_trip_timer #(.DLY_W(DLY_W)) u_oc_timer (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .enable_in   (chk_en[0]),
      .violate_in  (viol[0]),
      .tick_in     (mon_reg.tick),
      .delay_in    (mon_reg.oc_dly),
      .trip_out    (trips[0])
   );

   lpm_trip_timer #(.DLY_W(DLY_W)) u_op_timer (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .enable_in   (chk_en[1]),
      .violate_in  (viol[1]),
      .tick_in     (mon_reg.tick),
      .delay_in    (mon_reg.op_dly),
      .trip_out    (trips[1])
   );

   lpm_trip_timer #(.DLY_W(DLY_W)) u_uv_timer (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .enable_in   (chk_en[2]),
      .violate_in  (viol[2]),
      .tick_in     (mon_reg.tick),
      .delay_in    (mon_reg.uv_dly),
      .trip_out    (trips[2])
   );

   // Next-state logic for the whole block
   always_comb begin
      logic clr_req;
      logic on_req;
      logic off_req;
      logic host_clr;
      logic host_on;
      logic host_off;
      mon_next = mon_reg;
      host_clr = 1'b0;
      host_on  = 1'b0;
      host_off = 1'b0;
      clr_req  = 1'b0;
      on_req   = 1'b0;
      off_req  = 1'b0;
      mon_next.rdata = '0;

      // Shared timebase tick for delays and warm-up
      mon_next.tick = (mon_reg.tick_cnt == TICK_LAST);
      if (mon_reg.tick_cnt == TICK_LAST) begin
         mon_next.tick_cnt = '0;
      end else begin
         mon_next.tick_cnt = mon_reg.tick_cnt + 1'b1;
      end

      // Register writes
      if (wr_in) begin
         if (addr_in == OFS_CTRL) begin
            mon_next.ctrl = wdata_in[CTRL_W-1:0];
         end else if (addr_in == OFS_CMD) begin
            host_clr = wdata_in[CMD_CLEAR];
            host_on  = wdata_in[CMD_ON];
            host_off = wdata_in[CMD_OFF];
         end else if (addr_in == OFS_OC_LIM) begin
            mon_next.oc_lim = wdata_in[MEAS_W-1:0];
         end else if (addr_in == OFS_OC_DLY) begin
            mon_next.oc_dly = wdata_in[DLY_W-1:0];
         end else if (addr_in == OFS_OP_LIM) begin
            mon_next.op_lim = wdata_in[MEAS_W-1:0];
         end else if (addr_in == OFS_OP_DLY) begin
            mon_next.op_dly = wdata_in[DLY_W-1:0];
         end else if (addr_in == OFS_UV_LIM) begin
            mon_next.uv_lim = wdata_in[MEAS_W-1:0];
         end else if (addr_in == OFS_UV_DLY) begin
            mon_next.uv_dly = wdata_in[DLY_W-1:0];
         end else if (addr_in == OFS_UV_WARM) begin
            mon_next.uv_warm = wdata_in[DLY_W-1:0];
         end
      end

      // Register reads, data valid the following cycle; unmapped reads give zero
      if (rd_in) begin
         if (addr_in == OFS_CTRL) begin
            mon_next.rdata = DATA_W'(mon_reg.ctrl);
         end else if (addr_in == OFS_OC_LIM) begin
            mon_next.rdata = DATA_W'(mon_reg.oc_lim);
         end else if (addr_in == OFS_OC_DLY) begin
            mon_next.rdata = DATA_W'(mon_reg.oc_dly);
         end else if (addr_in == OFS_OP_LIM) begin
            mon_next.rdata = DATA_W'(mon_reg.op_lim);
         end else if (addr_in == OFS_OP_DLY) begin
            mon_next.rdata = DATA_W'(mon_reg.op_dly);
         end else if (addr_in == OFS_UV_LIM) begin
            mon_next.rdata = DATA_W'(mon_reg.uv_lim);
         end else if (addr_in == OFS_UV_DLY) begin
            mon_next.rdata = DATA_W'(mon_reg.uv_dly);
         end else if (addr_in == OFS_UV_WARM) begin
            mon_next.rdata = DATA_W'(mon_reg.uv_warm);
         end else if (addr_in == OFS_STAT) begin
            mon_next.rdata[STAT_PROT]      = (mon_reg.st == ST_PROT);
            mon_next.rdata[STAT_ON]        = mon_reg.load_on;
            mon_next.rdata[STAT_WARM_DONE] = mon_reg.warm_done;
            mon_next.rdata[STAT_CAUSE_LSB +: 3] = mon_reg.cause;
         end
      end

      // Clear sources: rear pulse edge, escape and enter keys, host command
      mon_next.rear_prev = rear_clear_in;
      clr_req = (rear_clear_in && !mon_reg.rear_prev) || keys_in.esc || keys_in.enter || host_clr;
      // The input key toggles the input; remote on and off are separate commands
      on_req  = host_on || (keys_in.input_key && mon_reg.st == ST_OFF);
      off_req = host_off || (keys_in.input_key && mon_reg.st == ST_ON);

      // Warm-up runs from input on; the undervoltage timer waits for it
      // warm-up count
      if (mon_reg.st == ST_ON && !mon_reg.warm_done) begin
         if (mon_reg.warm_arm && mon_reg.warm_cnt >= mon_reg.uv_warm) begin
            mon_next.warm_done = 1'b1;
         end else if (mon_reg.tick) begin
            // A partial first tick would cut the warm-up short, so it only arms the count
            mon_next.warm_arm = 1'b1;
            if (mon_reg.warm_arm) begin
               mon_next.warm_cnt = mon_reg.warm_cnt + 1'b1;
            end
         end
      end

      // Buzzer pulse countdown
      if (mon_reg.beep_cnt != '0) begin
         mon_next.beep_cnt = mon_reg.beep_cnt - 1'b1;
      end

      // Input state machine
      case (mon_reg.st)
         ST_OFF: begin
            if (on_req) begin
               mon_next.st        = ST_ON;
               mon_next.warm_cnt  = '0;
               mon_next.warm_done = 1'b0;
               mon_next.warm_arm  = 1'b0;
            end
         end
         ST_ON: begin
            if (trips != 3'b000) begin
               mon_next.st    = ST_PROT;
               mon_next.cause = trips;
               if (mon_reg.ctrl[CTRL_BEEP_EN]) begin
                  mon_next.beep_cnt = BEEP_LOAD;
               end
            end else if (off_req) begin
               mon_next.st = ST_OFF;
            end
         end
         ST_PROT: begin
            // latched until clear, then off; a clear in the first cycle of protection, while the entry trip is still held, is ignored
            if (clr_req && trips == 3'b000) begin
               mon_next.st    = ST_OFF;
               mon_next.cause = 3'b000;
            end
         end
         default: begin
            mon_next.st = ST_OFF;
         end
      endcase

      mon_next.load_on  = (mon_next.st == ST_ON);
      mon_next.prot_led = (mon_next.st == ST_PROT);
      mon_next.off_led  = (mon_next.st != ST_ON);
      mon_next.buzz     = (mon_next.beep_cnt != '0);

      mon_next.disp.active     = (mon_next.st == ST_PROT);
      mon_next.disp.line1_volt = meas_in.volt;
      mon_next.disp.line1_curr = meas_in.curr;
      // cause on line two, overcurrent first when several trip together
      if (mon_next.cause[0]) begin
         mon_next.disp.line2_cause = CAUSE_OC;
      end else if (mon_next.cause[1]) begin
         mon_next.disp.line2_cause = CAUSE_OP;
      end else if (mon_next.cause[2]) begin
         mon_next.disp.line2_cause = CAUSE_UV;
      end else begin
         mon_next.disp.line2_cause = CAUSE_NONE;
      end
   end

   // State register with documented reset values
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mon_reg         <= '0;
         mon_reg.st      <= ST_OFF;
         mon_reg.ctrl    <= CTRL_RST;
         mon_reg.oc_lim  <= HI_LIM_RST;
         mon_reg.op_lim  <= HI_LIM_RST;
         mon_reg.uv_lim  <= UV_LIM_RST;
         mon_reg.oc_dly  <= DLY_RST;
         mon_reg.op_dly  <= DLY_RST;
         mon_reg.uv_dly  <= DLY_RST;
         mon_reg.uv_warm <= DLY_RST;
         mon_reg.off_led <= 1'b1;
      end else begin
         mon_reg <= mon_next;
      end
   end

   // Outputs straight from the state register
   assign rdata_out         = mon_reg.rdata;
   assign load_on_out       = mon_reg.load_on;
   assign prot_led_out      = mon_reg.prot_led;
   assign off_led_out       = mon_reg.off_led;
   assign buzzer_out        = mon_reg.buzz;
   assign front_display_out = mon_reg.disp;
endmodule
`default_nettype wire

// ==== sim/lpm_monitor_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpm_monitor_sva #(
   parameter int BEEP_CYCLES = 20
) (
   input wire logic                  core_clk_in,
   input wire logic                  rstn_in,
   input wire logic                  wr_in,
   input wire lpm_pkg::lpm_meas_type meas_in,
   input wire lpm_pkg::lpm_keys_type keys_in,
   input wire logic                  rear_clear_in,
   input wire logic                  load_on_out,
   input wire logic                  prot_led_out,
   input wire logic                  off_led_out,
   input wire logic                  buzzer_out,
   input wire lpm_pkg::lpm_disp_type front_display_out
);
   import lpm_pkg::*;
   logic [3:0] since_clr_reg;
   int         beep_len_reg;

   // Age of the last clear source and length of the running beep; the age saturates
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         since_clr_reg <= 4'hF;
         beep_len_reg  <= 0;
      end else begin
         since_clr_reg <= (keys_in.esc || keys_in.enter || rear_clear_in || wr_in) ? 4'h0 :
                          (since_clr_reg == 4'hF ? 4'hF : since_clr_reg + 4'h1);
         beep_len_reg  <= buzzer_out ? beep_len_reg + 1 : 0;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   // Steps of entering and leaving protection
   sequence s_prot_entered;
      !prot_led_out ##1 prot_led_out;
   endsequence
   sequence s_prot_left;
      prot_led_out ##1 !prot_led_out;
   endsequence

   a_prot_forces_off: assert property (prot_led_out |-> !load_on_out && off_led_out)
      else $error("protection shown while input on");
   a_off_led_tracks: assert property (off_led_out == !load_on_out)
      else $error("off indicator disagrees with input state");
   a_trip_from_on: assert property (s_prot_entered |-> $past(load_on_out))
      else $error("protection entered while input was off");
   a_beep_on_entry: assert property ($rose(buzzer_out) |-> $rose(prot_led_out))
      else $error("buzzer started without entering protection");
   a_beep_length: assert property ($fell(buzzer_out) |-> beep_len_reg == BEEP_CYCLES)
      else $error("buzzer pulse has wrong length");
   a_cause_shown: assert property (prot_led_out |->
      front_display_out.active && front_display_out.line2_cause != CAUSE_NONE)
      else $error("protection shown without a cause");
   a_line_one_live: assert property ($past(rstn_in) && $past(rstn_in, 2) |->
      front_display_out.line1_volt == $past(meas_in.volt) && front_display_out.line1_curr == $past(meas_in.curr))
      else $error("first display line does not follow meters");
   a_latch_holds: assert property ($fell(prot_led_out) |-> since_clr_reg <= 4)
      else $error("protection dropped without a clear");
   a_clear_stays_off: assert property (s_prot_left |-> !load_on_out ##1 !load_on_out)
      else $error("input came back on with the clear");
endmodule

bind lpm_monitor lpm_monitor_sva #(.BEEP_CYCLES(BEEP_CYCLES)) u_sva (.core_clk_in, .rstn_in, .wr_in,
   .meas_in, .keys_in, .rear_clear_in, .load_on_out, .prot_led_out, .off_led_out, .buzzer_out,
   .front_display_out);
`default_nettype wire

// ==== sim/lpm_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpm_panel_model #(
   parameter int REAR_W = 3
) (
   input  wire logic             core_clk_in,
   input  wire logic             esc_req_in,
   input  wire logic             enter_req_in,
   input  wire logic             input_req_in,
   input  wire logic             rear_req_in,
   output lpm_pkg::lpm_keys_type keys_out,
   output logic                  rear_clear_out
);
   import lpm_pkg::*;
   int rear_cnt = 0;

   // panel key presses: one cycle each so a press counts once
   // rear clear: held a few cycles, since only the rising edge acts
   always @(posedge core_clk_in) begin
      keys_out <= '{esc: esc_req_in, enter: enter_req_in, input_key: input_req_in};
      rear_cnt <= rear_req_in ? REAR_W : (rear_cnt > 0 ? rear_cnt - 1 : 0);
   end
   assign rear_clear_out = (rear_cnt > 0);
endmodule
`default_nettype wire

// ==== sim/lpm_monitor_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module lpm_monitor_tb;
   import lpm_pkg::*;
   localparam int BEEP = 20;
   localparam logic [7:0]  RA [10] = '{OFS_CTRL, OFS_CMD, OFS_OC_LIM, OFS_OC_DLY, OFS_OP_LIM, OFS_OP_DLY,
      OFS_UV_LIM, OFS_UV_DLY, OFS_UV_WARM, 8'hFC};
   localparam logic [15:0] RV [10] = '{16'(CTRL_RST), 16'h0000, HI_LIM_RST, DLY_RST, HI_LIM_RST, DLY_RST,
      UV_LIM_RST, DLY_RST, DLY_RST, 16'h0000};
   localparam logic [15:0] CV [10] = '{16'h0000, 16'h0000, 16'h03E8, 16'h0003, 16'h03E8, 16'h0002,
      16'h01F4, 16'h0000, 16'h0002, 16'h0000};
   logic                core_clk_in = 0;
   logic                rstn_in = 0;
   logic [ADDR_W-1:0]   addr_in = '0;
   logic [DATA_W-1:0]   wdata_in = '0;
   logic                wr_in = 0;
   logic                rd_in = 0;
   logic [DATA_W-1:0]   rdata_out;
   lpm_meas_type        meas_in = '0;
   lpm_keys_type        keys_in;
   logic                rear_clear_in;
   logic                load_on_out;
   logic                prot_led_out;
   logic                off_led_out;
   logic                buzzer_out;
   lpm_disp_type        front_display_out;
   logic [3:0]          req = '0;
   logic                rd_seen = 0;
   logic [63:0]         exp_q [$];
   int                  failures = 0;
   int                  n_tests = 0;

   lpm_monitor #(.BEEP_CYCLES(BEEP)) DUT (.core_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .meas_in, .keys_in, .rear_clear_in, .load_on_out, .prot_led_out, .off_led_out,
      .buzzer_out, .front_display_out);
   lpm_panel_model u_panel (.core_clk_in, .esc_req_in(req[0]), .enter_req_in(req[1]),
      .input_req_in(req[2]), .rear_req_in(req[3]), .keys_out(keys_in), .rear_clear_out(rear_clear_in));

   initial begin
      forever #5 core_clk_in = ~core_clk_in;
   end

   // Read data stand only in the cycle after the strobe; the oldest note is its expectation
   always @(posedge core_clk_in) rd_seen <= rd_in;
   always @(negedge core_clk_in) begin
      logic [63:0] e;
      if (rd_seen) begin
         e = exp_q.pop_front();
         `CHK("rdata", e[31:0], rdata_out & e[63:32])
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      exp_q.push_back({m, ex & m});
      @(posedge core_clk_in);
      rd_in <= 1'b0;
   endtask

   // One request pulse to the panel model: 0 escape, 1 enter, 2 input key, 3 rear clear
   task automatic press(input int k);
      @(posedge core_clk_in);
      req[k] <= 1'b1;
      @(posedge core_clk_in);
      req[k] <= 1'b0;
   endtask

   task automatic set_meas(input logic [15:0] v, input logic [15:0] c, input logic [15:0] p);
      @(posedge core_clk_in);
      meas_in <= '{volt: v, curr: c, pow: p};
   endtask

   // Random meter values that break no limit of the test set-up
   task automatic safe();
      set_meas(16'h03E8 + 16'($urandom_range(16'h03E7)), 16'($urandom_range(16'h03E7)),
         16'($urandom_range(16'h03E7)));
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Bounded wait on protection (sel 0) or input state (sel 1); a timeout ends the run
   task automatic wait_for(input int sel, input logic lvl, input int bound, output int n);
      n = 0;
      do begin
         @(negedge core_clk_in);
         n++;
      end while ((sel ? load_on_out : prot_led_out) !== lvl && n < bound);
      if ((sel ? load_on_out : prot_led_out) !== lvl) begin
         failures++;
         $display("MISMATCH wait expected %0h seen timeout", lvl);
         tally_and_finish();
      end
   endtask

   initial begin
      int n;
      int chk;
      logic beep;
      logic [31:0] v;
      void'($urandom(32'h0636));
      repeat (20) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      // Reset values, the command word and an unmapped word all read as documented
      for (int i = 0; i < 10; i++) rd(RA[i], 32'(RV[i]), 32'hFFFF_FFFF);
      rd(8'h24, 32'h0000_0000, 32'h0000_0073);
      // Limits, delays and warm-up keep what software wrote in their 16 bits
      for (int i = 2; i < 9; i++) begin
         v = $urandom();
         wr(RA[i], v);
         rd(RA[i], {16'h0000, v[15:0]}, 32'hFFFF_FFFF);
      end
      for (int i = 2; i < 9; i++) wr(RA[i], 32'(CV[i]));
      safe();
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_CMD, 32'h0000_0002);
      wait_for(1, 1'b1, 10, n);
      // Overload on disabled checks is ignored
      set_meas(16'h07D0, 16'h07D0, 16'h07D0);
      repeat (400) @(negedge core_clk_in);
      `CHK("disabled", 1'b0, prot_led_out)
      // Two bursts shorter than the delay, split by one clean cycle, must not add up
      wr(OFS_CTRL, 32'h0000_0001);
      repeat (2) begin
         set_meas(16'h07D0, 16'h07D0, 16'h0000);
         repeat (150) @(negedge core_clk_in);
         safe();
      end
      `CHK("bursts", 1'b0, prot_led_out)
      // Current equal to the limit is no overload
      set_meas(16'h07D0, 16'h03E8, 16'h0000);
      repeat (400) @(negedge core_clk_in);
      `CHK("at_limit", 1'b0, prot_led_out)
      wr(OFS_OC_DLY, 32'h0000_0002);
      // Each check trips in turn, is cleared by another method and re-enabled
      for (int k = 0; k < 4; k++) begin
         chk = k % 3;
         beep = k[0];
         wr(OFS_CTRL, 32'({beep, 3'b000} | (1 << chk)));
         case (chk)
            0: set_meas(16'h07D0, 16'h0BB8, 16'h0000);
            1: set_meas(16'h07D0, 16'h0000, 16'h0BB8);
            default: set_meas(16'h0064, 16'h0000, 16'h0000);
         endcase
         wait_for(0, 1'b1, 600, n);
         // The overcurrent and overpower delays and the warm-up each ask for two whole ticks before a trip
         `CHK("trip_time", 1'b1, n >= 2 * TICK_CYC)
         `CHK("buzzer", beep, buzzer_out)
         `CHK("input_off", 1'b0, load_on_out)
         `CHK("off_led", 1'b1, off_led_out)
         `CHK("disp_on", 1'b1, front_display_out.active)
         `CHK("cause", lpm_cause_type'(chk + 1), front_display_out.line2_cause)
         `CHK("line_volt", meas_in.volt, front_display_out.line1_volt)
         `CHK("line_curr", meas_in.curr, front_display_out.line1_curr)
         safe();
         repeat (30) @(negedge core_clk_in);
         `CHK("latched", 1'b1, prot_led_out)
         rd(8'h24, 32'h0000_0001 | (32'h0000_0010 << chk), 32'h0000_0073);
         case (k)
            0: press(0);
            1: press(1);
            2: press(3);
            default: wr(OFS_CMD, 32'h0000_0001);
         endcase
         wait_for(0, 1'b0, 10, n);
         repeat (5) @(negedge core_clk_in);
         `CHK("stays_off", 1'b0, load_on_out)
         if (k[0]) press(2);
         else wr(OFS_CMD, 32'h0000_0002);
         wait_for(1, 1'b1, 10, n);
      end
      // Remote off and the input key both switch a conducting input off
      wr(OFS_CMD, 32'h0000_0004);
      wait_for(1, 1'b0, 10, n);
      `CHK("remote_off", 1'b1, off_led_out)
      press(2);
      wait_for(1, 1'b1, 10, n);
      press(2);
      wait_for(1, 1'b0, 10, n);
      `CHK("key_off", 1'b0, prot_led_out)
      tally_and_finish();
   end
endmodule
`default_nettype wire
